// File: dv/flash_array_model.sv
`timescale 1ns/1ps

module flash_array_model (
  // clock
  input wire logic ref_clk,
  // array access
  input wire logic [15:0] fl_addr,
  input wire logic [15:0] fl_wdata,
  input wire logic fl_word_we,
  input wire logic fl_page_erase,
  input wire logic fl_rd,
  output logic [15:0] fl_rdata
);
  logic [15:0] mem [0:65535];
  logic [15:0] last;

  initial begin
    last = 16'h0000;
    for (int i = 0; i < 65536; i++) begin
      mem[i] = i[15:0] ^ 16'h5A3C;
    end
  end

  always @(posedge ref_clk) begin
    // whole page from bits 15..7 goes blank
    if (fl_page_erase) begin
      for (int i = 0; i < 128; i++) begin
        mem[{fl_addr[15:7], i[6:0]}] <= 16'h0000;
      end
    end
    if (fl_word_we) begin
      mem[fl_addr] <= fl_wdata;
    end
    if (fl_rd) begin
      last <= mem[fl_addr];
    end
  end

  // idle array shows the inverse, never a stale word
  assign fl_rdata = fl_rd ? mem[fl_addr] : ~last;
endmodule : flash_array_model

// File: dv/tb_iap_flash_program_sequencer.sv
`timescale 1ns/1ps
`include "iap_defs.svh"

module tb_iap_flash_program_sequencer;
  localparam int ES = 20;
  localparam int EL = 30;
  localparam int UC = 24;
  logic ref_clk, nrst;
  logic [7:0] stb, wr_data;
  logic [1:0] key_index;
  logic [2:0] operation_select;
  logic program_unlocked_flag, unlock_arm_bit, write_initiate_bit;
  logic read_enable_bit, read_initiate_bit, duration_select_bit;
  logic buffer_clear_bit, cpu_stall, fl_word_we, fl_page_erase, fl_rd;
  logic [15:0] flash_addr, fl_addr, fl_wdata, fl_rdata;
  logic [7:0] data_word_zero_low, data_word_zero_high;
  logic [15:0] expq [$];
  logic [15:0] w [0:3];
  logic prev_rd;
  int n_fail, checks, n_we, n_er, n;

  iap_flash_program_sequencer #(.ERASE_SHORT_CYC(ES), .ERASE_LONG_CYC(EL),
    .WRITE_SHORT_CYC(ES), .WRITE_LONG_CYC(EL), .UNLOCK_CYC(UC)) dut (
    .ref_clk(ref_clk), .nrst(nrst), .wr_data(wr_data),
    .wr_ctrl_first(stb[0]), .wr_ctrl_second(stb[1]),
    .wr_addr_low(stb[2]), .wr_addr_high(stb[3]),
    .wr_data0_low(stb[4]), .wr_data0_high(stb[5]),
    .wr_key_low(stb[6]), .wr_key_high(stb[7]), .key_index(key_index),
    .operation_select(operation_select),
    .program_unlocked_flag(program_unlocked_flag),
    .unlock_arm_bit(unlock_arm_bit), .write_initiate_bit(write_initiate_bit),
    .read_enable_bit(read_enable_bit), .read_initiate_bit(read_initiate_bit),
    .duration_select_bit(duration_select_bit),
    .buffer_clear_bit(buffer_clear_bit), .flash_addr(flash_addr),
    .data_word_zero_low(data_word_zero_low),
    .data_word_zero_high(data_word_zero_high), .cpu_stall(cpu_stall),
    .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_word_we(fl_word_we),
    .fl_page_erase(fl_page_erase), .fl_rd(fl_rd), .fl_rdata(fl_rdata));

  flash_array_model array (.ref_clk(ref_clk), .fl_addr(fl_addr),
    .fl_wdata(fl_wdata), .fl_word_we(fl_word_we),
    .fl_page_erase(fl_page_erase), .fl_rd(fl_rd), .fl_rdata(fl_rdata));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task final_report;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  // one strobe per call, released before the next one rises
  task wr(input int s, input logic [7:0] d, input logic [1:0] k = 2'h0);
    @(posedge ref_clk);
    stb <= 8'h01 << s;
    wr_data <= d;
    key_index <= k;
    @(posedge ref_clk);
    stb <= 8'h00;
    #1;
  endtask : wr

  task wait_op(output int c);
    c = 0;
    while (cpu_stall === 1'b1 && c < 400) begin
      @(posedge ref_clk);
      #1;
      c++;
    end
  endtask : wait_op

  task set_addr(input logic [15:0] a);
    wr(2, a[7:0]);
    wr(3, a[15:8]);
  endtask : set_addr

  task rd(input logic [15:0] a, input logic [15:0] exp);
    set_addr(a);
    expq.push_back(exp);
    wr(0, 8'hB3);
    wait_op(n);
    chk(16'(n), 16'h0003);
    chk({operation_select, read_enable_bit}, 4'h7);
  endtask : rd

  task unlock(input logic [7:0] last_hi);
    wr(0, 8'hE8);
    chk(unlock_arm_bit, 1'b1);
    wr(6, `KEY1_LO, 2'h1);
    wr(6, `KEY2_LO, 2'h2);
    wr(6, `KEY3_LO, 2'h3);
    wr(7, `KEY1_HI, 2'h1);
    wr(7, `KEY2_HI, 2'h2);
    wr(7, last_hi, 2'h3);
  endtask : unlock

  task load(input logic [15:0] v);
    wr(4, v[7:0]);
    wr(5, v[15:8]);
  endtask : load

  // read results are compared as the read bit drops
  always @(negedge ref_clk) begin
    prev_rd <= read_initiate_bit;
    if (prev_rd === 1'b1 && read_initiate_bit === 1'b0) begin
      if (expq.size() == 0) begin
        chk(16'hFFFF, 16'h0000);
      end else begin
        chk({data_word_zero_high, data_word_zero_low}, expq.pop_front());
      end
    end
  end

  always @(posedge ref_clk) begin
    if (fl_word_we === 1'b1) n_we++;
    if (fl_page_erase === 1'b1) n_er++;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    final_report;
  end

  initial begin
    nrst = 1'b0;
    stb = 8'h00;
    wr_data = 8'h00;
    key_index = 2'h0;
    prev_rd = 1'b0;
    void'($urandom(32'h7800));
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    #1;
    chk({program_unlocked_flag, unlock_arm_bit, cpu_stall}, 3'h0);
    rd(16'h1280, 16'h1280 ^ 16'h5A3C);
    wr(0, 8'h94);
    chk({write_initiate_bit, cpu_stall}, 2'h0);
    $display("locked access test done");
    unlock(8'h41);
    repeat (UC + 4) @(posedge ref_clk);
    #1;
    chk({unlock_arm_bit, program_unlocked_flag}, 2'h0);
    // unlock before any erase or write
    unlock(`KEY3_HI);
    repeat (3) @(posedge ref_clk);
    #1;
    chk({program_unlocked_flag, unlock_arm_bit}, 2'h2);
    $display("unlock test done");
    // dummy tags step the address, then short erase
    set_addr(16'h1280);
    wr(5, 8'h00);
    wr(5, 8'h00);
    chk(flash_addr, 16'h1282);
    // page erased before it is programmed
    wr(1, 8'h01);
    wr(0, 8'h94);
    wait_op(n);
    chk(n >= ES && n <= ES + 8, 1'b1);
    chk({n_er[3:0], write_initiate_bit}, 5'h02);
    rd(16'h12C4, 16'h0000);
    $display("erase test done");
    for (int i = 0; i < 4; i++) w[i] = 16'($urandom);
    set_addr(16'h12FD);
    wr(4, w[0][7:0]);
    chk({data_word_zero_low, flash_addr}, {w[0][7:0], 16'h12FD});
    wr(5, w[0][15:8]);
    chk(flash_addr, 16'h12FE);
    load(w[1]);
    load(w[2]);
    load(w[3]);
    chk(flash_addr, 16'h12FF);
    wr(1, 8'h02);
    chk(duration_select_bit, 1'b1);
    wr(0, 8'h84);
    wait_op(n);
    chk(n >= EL + 128 && n <= EL + 140, 1'b1);
    chk(16'(n_we), 16'h0003);
    rd(16'h12FD, w[0]);
    rd(16'h12FF, w[3]);
    $display("program test done");
    // clear, reload one word, rewrite without erase
    wr(1, 8'h01);
    chk(buffer_clear_bit, 1'b1);
    @(posedge ref_clk);
    #1;
    chk(buffer_clear_bit, 1'b0);
    set_addr(16'h12FE);
    load(~w[1]);
    wr(0, 8'h84);
    wait_op(n);
    chk(n >= ES + 128 && n <= ES + 140, 1'b1);
    chk(16'(n_we), 16'h0004);
    rd(16'h12FE, ~w[1]);
    rd(16'h12FD, w[0]);
    $display("rewrite test done");
    wr(0, 8'h00);
    chk(program_unlocked_flag, 1'b0);
    wr(0, 8'h84);
    chk({write_initiate_bit, cpu_stall}, 2'h0);
    repeat (4) @(posedge ref_clk);
    chk(16'(expq.size()), 16'h0000);
    $display("relock test done");
    final_report;
  end
endmodule : tb_iap_flash_program_sequencer

// File: verilog/cycle_countdown.sv
`timescale 1ns/1ps

module cycle_countdown #(
  parameter int W = 20
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // control
  input wire logic start,
  input wire logic [W-1:0] load,
  // status
  output logic busy,
  output logic done
);

  logic [W-1:0] count;

  // runs load cycles after start, then one done pulse
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      count <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count <= load;
        busy <= 1'b1;
      end else if (busy) begin
        count <= count - W'(1);
        if (count <= W'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule : cycle_countdown

// File: verilog/iap_defs.svh
`ifndef IAP_DEFS_SVH
`define IAP_DEFS_SVH

// system clock
`define CLK_PERIOD_NS 8

// first control register fields
`define CF_FLAG 7
`define CF_OPSEL 6:4
`define CF_ARM 3
`define CF_WRITE 2
`define CF_RDEN 1
`define CF_READ 0

// second control register fields
`define CS_DUR 1
`define CS_CLR 0

// unlock key, words one to three
`define KEY1_LO 8'h00
`define KEY2_LO 8'h0D
`define KEY3_LO 8'hC3
`define KEY1_HI 8'h04
`define KEY2_HI 8'h09
`define KEY3_HI 8'h40

// operation times
`define ERASE_SHORT_NS 4700000
`define ERASE_LONG_NS 5200000
`define WRITE_SHORT_NS 2700000
`define WRITE_LONG_NS 3250000
`define READ_CYCLES 3
`define UNLOCK_WINDOW_CYCLES 2048

// page geometry
`define PAGE_WORDS 128
`define PAGE_LAST 7'h7F
`define PAGE_FIRST 7'h00

`endif

// File: verilog/iap_flash_program_sequencer.sv
`timescale 1ns/1ps
`include "iap_defs.svh"

// Contract
// [R01] operation select value 110 chooses the unlock mode
// [R02] setting the arm bit starts the procedure timer at once
// [R03] six key bytes 00 0D C3 / 04 09 40 are compared while armed
// [R04] timer expiry clears the arm bit whatever key was written
// [R05] wrong key leaves erase/write disabled, right key enables it
// [R06] clearing the unlocked flag disables erase/write immediately
// [R07] 128-word write buffer maps to page given by address bits 15..7
// [R08] each high-byte data load advances the buffer address by one
// [R09] address holds at the last word of the page
// [R10] mode 001 plus write-initiate erases the page, bit clears at end
// [R11] mode 000 plus write-initiate programs the buffer, bit clears at end
// [R12] buffer-clear bit empties the write buffer
// [R13] processor stalls while erase, write or read runs
// [R14] erase/write duration follows the duration-select bit
// [R15] read: mode 011, read enable, address, then read-initiate
// [R16] read result appears in data word zero when read bit drops
// [R17] read completes in three cycles
// [R18] reads work without the unlock procedure
// [R19] clear, reload and rewrite same page without new erase
// [R20] software erases a page before programming it
// [R21] software unlocks before any erase or write
// [R22] accepted key sets the unlocked flag
// [R23] low data byte only stores, high byte loads the whole word
// [R24] dummy high-byte writes tag erase addresses and advance address
// [R25] buffer-clear bit self-clears when clearing is done
// [R26] erase/write requests are ignored while locked
module iap_flash_program_sequencer #(
  parameter int TW = 20,
  parameter int ERASE_SHORT_CYC = `ERASE_SHORT_NS / `CLK_PERIOD_NS,
  parameter int ERASE_LONG_CYC = `ERASE_LONG_NS / `CLK_PERIOD_NS,
  parameter int WRITE_SHORT_CYC = `WRITE_SHORT_NS / `CLK_PERIOD_NS,
  parameter int WRITE_LONG_CYC = `WRITE_LONG_NS / `CLK_PERIOD_NS,
  parameter int UNLOCK_CYC = `UNLOCK_WINDOW_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // software writes, one strobe per register
  input wire logic [7:0] wr_data,
  input wire logic wr_ctrl_first,
  input wire logic wr_ctrl_second,
  input wire logic wr_addr_low,
  input wire logic wr_addr_high,
  input wire logic wr_data0_low,
  input wire logic wr_data0_high,
  input wire logic wr_key_low,
  input wire logic wr_key_high,
  input wire logic [1:0] key_index,
  // register state seen by software
  output logic [2:0] operation_select,
  output logic program_unlocked_flag,
  output logic unlock_arm_bit,
  output logic write_initiate_bit,
  output logic read_enable_bit,
  output logic read_initiate_bit,
  output logic duration_select_bit,
  output logic buffer_clear_bit,
  output logic [15:0] flash_addr,
  output logic [7:0] data_word_zero_low,
  output logic [7:0] data_word_zero_high,
  output logic cpu_stall,
  // flash array
  output logic [15:0] fl_addr,
  output logic [15:0] fl_wdata,
  output logic fl_word_we,
  output logic fl_page_erase,
  output logic fl_rd,
  input wire logic [15:0] fl_rdata
);

  iap_pkg::seq_state_t state;
  logic [7:0] key_lo [3];
  logic [7:0] key_hi [3];
  logic key_match;
  logic arm_go;
  logic wr_go;
  logic rd_go;
  logic [2:0] new_mode;
  logic [15:0] wbuf [`PAGE_WORDS];
  logic [`PAGE_WORDS-1:0] wvalid;
  logic [6:0] pidx;
  logic [1:0] rcnt;
  logic [TW-1:0] op_load;
  logic op_start;
  logic op_done;
  logic unlock_done;

  assign new_mode = wr_data[`CF_OPSEL];
  assign cpu_stall = (state != iap_pkg::ST_IDLE);

  // [R01] unlock mode select
  assign arm_go = wr_ctrl_first && wr_data[`CF_ARM]
    && (new_mode == iap_pkg::MODE_UNLOCK);
  // [R26] locked requests dropped
  assign wr_go = wr_ctrl_first && wr_data[`CF_WRITE]
    && program_unlocked_flag && (state == iap_pkg::ST_IDLE)
    && (new_mode == iap_pkg::MODE_WRITE
      || new_mode == iap_pkg::MODE_ERASE);
  // [R15] [R18] read needs no unlock
  assign rd_go = wr_ctrl_first && wr_data[`CF_READ]
    && wr_data[`CF_RDEN] && (state == iap_pkg::ST_IDLE)
    && (new_mode == iap_pkg::MODE_READ);

  // [R03] six-byte key compare
  assign key_match = key_lo[0] == `KEY1_LO && key_lo[1] == `KEY2_LO
    && key_lo[2] == `KEY3_LO && key_hi[0] == `KEY1_HI
    && key_hi[1] == `KEY2_HI && key_hi[2] == `KEY3_HI;

  // [R02] timer starts with arm
  cycle_countdown #(.W(TW)) u_unlock_timer (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .start(arm_go),
    .load(TW'(UNLOCK_CYC)),
    .busy(),
    .done(unlock_done)
  );

  // [R14] duration from select bit
  always_comb begin
    if (operation_select == iap_pkg::MODE_ERASE) begin
      op_load = duration_select_bit ? TW'(ERASE_LONG_CYC)
        : TW'(ERASE_SHORT_CYC);
    end else begin
      op_load = duration_select_bit ? TW'(WRITE_LONG_CYC)
        : TW'(WRITE_SHORT_CYC);
    end
  end

  cycle_countdown #(.W(TW)) u_op_timer (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .start(op_start),
    .load(op_load),
    .busy(),
    .done(op_done)
  );

  // mode and enable fields
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      operation_select <= iap_pkg::MODE_WRITE;
      read_enable_bit <= 1'b0;
      duration_select_bit <= 1'b0;
    end else begin
      if (wr_ctrl_first) begin
        operation_select <= new_mode;
        read_enable_bit <= wr_data[`CF_RDEN];
      end
      if (wr_ctrl_second) begin
        duration_select_bit <= wr_data[`CS_DUR];
      end
    end
  end

  // [R04] arm ends on timeout or on acceptance
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      unlock_arm_bit <= 1'b0;
    end else if (arm_go) begin
      unlock_arm_bit <= 1'b1;
    end else if (unlock_done || key_match) begin
      unlock_arm_bit <= 1'b0;
    end
  end

  // [R05] keys reset on arm (low bytes 00, high bytes FF) so stale bytes never unlock
  always_ff @(posedge ref_clk) begin
    if (!nrst || arm_go) begin
      key_lo <= '{3{8'h00}};
      key_hi <= '{3{8'hFF}};
    end else if (key_index != 2'h0) begin
      if (wr_key_low) begin
        key_lo[key_index - 2'h1] <= wr_data;
      end
      if (wr_key_high) begin
        key_hi[key_index - 2'h1] <= wr_data;
      end
    end
  end

  // [R22] set beats a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      program_unlocked_flag <= 1'b0;
    end else if (unlock_arm_bit && key_match) begin
      program_unlocked_flag <= 1'b1;
    // [R06] software clear locks at once
    end else if (wr_ctrl_first && !wr_data[`CF_FLAG]) begin
      program_unlocked_flag <= 1'b0;
    end
  end

  // [R10] initiate bit held until timer done
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      write_initiate_bit <= 1'b0;
    end else if (wr_go) begin
      write_initiate_bit <= 1'b1;
    end else if (op_done) begin
      write_initiate_bit <= 1'b0;
    end
  end

  // [R25] buffer clear takes one cycle; a new set wins over self-clear
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      buffer_clear_bit <= 1'b0;
    end else if (wr_ctrl_second && wr_data[`CS_CLR]) begin
      buffer_clear_bit <= 1'b1;
    end else if (buffer_clear_bit) begin
      buffer_clear_bit <= 1'b0;
    end
  end

  // [R09] low seven bits stop at page end
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      flash_addr <= 16'h0000;
    end else if (wr_addr_low) begin
      flash_addr[7:0] <= wr_data;
    end else if (wr_addr_high) begin
      flash_addr[15:8] <= wr_data;
    // [R08] step per loaded word
    end else if (wr_data0_high && flash_addr[6:0] != `PAGE_LAST) begin
      flash_addr[6:0] <= flash_addr[6:0] + 7'h01;
    end
  end

  // [R23] low byte only stores
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      data_word_zero_low <= 8'h00;
      data_word_zero_high <= 8'h00;
    // [R16] read result into data word zero
    end else if (state == iap_pkg::ST_READ && rcnt == 2'h0) begin
      data_word_zero_low <= fl_rdata[7:0];
      data_word_zero_high <= fl_rdata[15:8];
    end else begin
      if (wr_data0_low) begin
        data_word_zero_low <= wr_data;
      end
      if (wr_data0_high) begin
        data_word_zero_high <= wr_data;
      end
    end
  end

  // [R07] one page of buffered words
  for (genvar e = 0; e < `PAGE_WORDS; e++) begin : g_wbuf
    always_ff @(posedge ref_clk) begin
      // [R12] clear empties every entry
      if (!nrst || buffer_clear_bit) begin
        wbuf[e] <= 16'h0000;
        wvalid[e] <= 1'b0;
      // [R24] high-byte write loads and tags
      end else if (wr_data0_high && flash_addr[6:0] == 7'(e)) begin
        wbuf[e] <= {wr_data, data_word_zero_low};
        wvalid[e] <= 1'b1;
      end
    end
  end

  // read-initiate bit, cleared with the captured word
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      read_initiate_bit <= 1'b0;
    end else if (rd_go) begin
      read_initiate_bit <= 1'b1;
    end else if (state == iap_pkg::ST_READ && rcnt == 2'h0) begin
      read_initiate_bit <= 1'b0;
    end
  end

  // [R13] sequencer; stall follows any non-idle state
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state <= iap_pkg::ST_IDLE;
      pidx <= `PAGE_FIRST;
      rcnt <= 2'h0;
      op_start <= 1'b0;
      fl_addr <= 16'h0000;
      fl_wdata <= 16'h0000;
      fl_word_we <= 1'b0;
      fl_page_erase <= 1'b0;
      fl_rd <= 1'b0;
    end else begin
      op_start <= 1'b0;
      fl_word_we <= 1'b0;
      fl_page_erase <= 1'b0;
      case (state)
        iap_pkg::ST_IDLE: begin
          pidx <= `PAGE_FIRST;
          if (wr_go && new_mode == iap_pkg::MODE_ERASE) begin
            state <= iap_pkg::ST_ERASE;
          end else if (wr_go) begin
            state <= iap_pkg::ST_PROG;
          end else if (rd_go) begin
            // [R17] three cycle read
            rcnt <= 2'(`READ_CYCLES - 1);
            fl_addr <= flash_addr;
            fl_rd <= 1'b1;
            state <= iap_pkg::ST_READ;
          end
        end
        iap_pkg::ST_ERASE: begin
          fl_addr <= {flash_addr[15:7], `PAGE_FIRST};
          fl_page_erase <= 1'b1;
          op_start <= 1'b1;
          state <= iap_pkg::ST_WAIT;
        end
        // [R11] walk the page, program tagged words only
        iap_pkg::ST_PROG: begin
          fl_addr <= {flash_addr[15:7], pidx};
          fl_wdata <= wbuf[pidx];
          fl_word_we <= wvalid[pidx];
          pidx <= pidx + 7'h01;
          if (pidx == `PAGE_LAST) begin
            op_start <= 1'b1;
            state <= iap_pkg::ST_WAIT;
          end
        end
        // [R19] buffer survives, so a rewrite needs no erase
        iap_pkg::ST_WAIT: begin
          if (op_done) begin
            state <= iap_pkg::ST_IDLE;
          end
        end
        iap_pkg::ST_READ: begin
          rcnt <= rcnt - 2'h1;
          if (rcnt == 2'h0) begin
            fl_rd <= 1'b0;
            state <= iap_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= iap_pkg::ST_IDLE;
        end
      endcase
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  sequence read_run;
    read_initiate_bit [*3];
  endsequence

  sequence read_end;
    !read_initiate_bit && !cpu_stall;
  endsequence

  chk_unlock_mode: // [R01]
    assert property ($rose(unlock_arm_bit) |->
      operation_select == iap_pkg::MODE_UNLOCK)
    else $error("arm set outside unlock mode");

  chk_arm_expiry: // [R04]
    assert property (unlock_done && !arm_go |=> !unlock_arm_bit)
    else $error("arm bit survived timeout");

  chk_key_accept: // [R22]
    assert property (unlock_arm_bit && key_match |=>
      program_unlocked_flag)
    else $error("good key not accepted");

  chk_bad_key: // [R05]
    assert property ($rose(program_unlocked_flag) |->
      $past(unlock_arm_bit && key_match))
    else $error("unlocked without good key");

  chk_lock_clear: // [R06]
    assert property (wr_ctrl_first && !wr_data[`CF_FLAG]
      && !(unlock_arm_bit && key_match) |=> !program_unlocked_flag)
    else $error("flag clear ignored");

  chk_addr_step: // [R08]
    assert property (wr_data0_high && !wr_addr_low && !wr_addr_high
      && flash_addr[6:0] != `PAGE_LAST |=>
      flash_addr[6:0] == $past(flash_addr[6:0]) + 7'h01)
    else $error("address did not step");

  chk_addr_hold: // [R09]
    assert property (wr_data0_high && !wr_addr_low
      && flash_addr[6:0] == `PAGE_LAST |=> flash_addr[6:0] == `PAGE_LAST)
    else $error("address passed page end");

  chk_lock_ignore: // [R26]
    assert property (wr_ctrl_first && wr_data[`CF_WRITE]
      && !program_unlocked_flag && !write_initiate_bit
      |=> !write_initiate_bit && state != iap_pkg::ST_ERASE
      && state != iap_pkg::ST_PROG)
    else $error("locked request started");

  chk_op_stall: // [R13]
    assert property (write_initiate_bit || read_initiate_bit |->
      cpu_stall)
    else $error("operation without stall");

  chk_op_length: // [R10] [R11]
    assert property ($fell(write_initiate_bit) |-> $past(op_done))
    else $error("initiate dropped before timer");

  chk_read_time: // [R17]
    assert property ($rose(read_initiate_bit) |-> read_run ##1 read_end)
    else $error("read not three cycles");

  chk_read_data: // [R16]
    assert property ($fell(read_initiate_bit) |->
      {data_word_zero_high, data_word_zero_low} == $past(fl_rdata))
    else $error("read word not presented");

  chk_clear_auto: // [R25]
    assert property (buffer_clear_bit
      && !(wr_ctrl_second && wr_data[`CS_CLR])
      |=> !buffer_clear_bit && !wvalid[0])
    else $error("buffer clear stuck");

endmodule : iap_flash_program_sequencer

// File: verilog/iap_pkg.sv
package iap_pkg;

  typedef enum logic [2:0] {
    MODE_WRITE = 3'h0,
    MODE_ERASE = 3'h1,
    MODE_READ = 3'h3,
    MODE_UNLOCK = 3'h6
  } op_mode_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ERASE = 5'h02,
    ST_PROG = 5'h04,
    ST_WAIT = 5'h08,
    ST_READ = 5'h10
  } seq_state_t;

endpackage : iap_pkg
